// ### logic/wdws_watchdog.sv
// Watchdog timer with its mode register and the cold or warm start bit.
`timescale 1ns/10ps
module wdws_watchdog
  import wdws_pkg::*;
(
  // Clock and power-on reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Core status and events.
  input wire logic ext_rst_in,
  input wire logic first_instr_in,
  input wire logic wdog_instr_in,
  input wire logic halt_in,
  input wire logic stop_in,
  // Wake source and oscillator.
  input wire logic recovery_src_in,
  input wire logic rc_tick_in,
  // Expanded register port.
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_bank_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Restart requests to the core.
  output logic cpu_reset_out,
  output logic stop_wake_out,
  // Status.
  output logic wdog_running_out,
  output logic write_window_out,
  // Condition flag update.
  output logic flag_we_out,
  output logic [2:0] flag_zsv_out
);

  // ************************************************************
  // Declarations
  // ************************************************************

  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic running_r;
  logic running_nxt;
  logic cold_warm_r;
  logic cold_warm_nxt;
  logic edge_sel_r;
  logic edge_sel_nxt;
  wdws_win_type win_state_r;
  wdws_win_type win_state_nxt;
  logic [WDWS_WIN_W-1:0] win_cnt_r;
  logic [WDWS_WIN_W-1:0] win_cnt_nxt;
  logic win_open_r;
  logic cpu_reset_r;
  logic stop_wake_r;
  logic flag_we_r;
  logic [2:0] flag_zsv_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  wire logic sel_bank;
  wire logic sel_mode;
  wire logic sel_ctrl;
  wire logic mode_wr;
  wire logic ctrl_wr;
  wire logic wake_level;
  wire logic wake_now;
  wire logic terminal;
  wire logic timeout_fire;
  wire logic restart;
  wire logic halt_block;
  wire logic stop_block;
  wire logic count_tick;
  wire logic count_clear;
  wire logic [1:0] tap_sel;
  wire logic [WDWS_CNT_W-1:0] tap_limit;
  wire logic win_done;

  // ************************************************************
  // Register decode
  // ************************************************************

  // Both registers live in bank F of the expanded group.
  assign sel_bank = (reg_bank_in == WDWS_BANK_F);
  assign sel_mode = sel_bank && (reg_addr_in == WDWS_ADDR_WDOG_MODE);
  assign sel_ctrl = sel_bank && (reg_addr_in == WDWS_ADDR_STOP_CTRL);

  // A mode write only lands while the window is open.
  assign mode_wr = reg_wr_in && sel_mode && (win_state_r == WDWS_WIN_OPEN);
  assign ctrl_wr = reg_wr_in && sel_ctrl;

  // ************************************************************
  // Restart sources
  // ************************************************************

  // Stop recovery fires when the source sits at the selected level.
  assign wake_level = (recovery_src_in == edge_sel_r);
  // The pulse register blocks a repeat only in the cycle right after a wake pulse.
  assign wake_now = stop_in && wake_level && !stop_wake_r;

  // Terminal count only matters while the watchdog is armed.
  assign timeout_fire = terminal && running_r;

  // Any of these disarms the watchdog and sends the mode window back to waiting; only a timeout raises cpu_reset_out.
  assign restart = timeout_fire || wake_now || ext_rst_in;

  // ************************************************************
  // Counting conditions
  // ************************************************************

  // Halt and stop freeze the count unless the mode asks otherwise.
  assign halt_block = halt_in && !mode_r[WDWS_HALT_RUN_BIT];
  assign stop_block = stop_in && !mode_r[WDWS_STOP_RUN_BIT];
  // The chain only steps on an oscillator tick, not on clock_in alone.
  assign count_tick = running_r && rc_tick_in && !halt_block && !stop_block;
  // Servicing or any restart brings the count back to zero.
  assign count_clear = restart || wdog_instr_in || !running_r;

  // Tap select picks the limit; mode bits above bit 3 are never looked at.
  assign tap_sel = mode_r[WDWS_TAP_MSB:WDWS_TAP_LSB];
  assign tap_limit = WDWS_TAP_LIMIT[tap_sel];

  // ************************************************************
  // Count chain
  // ************************************************************

  // Retriggerable count chain with the selected terminal count.
  wdws_tap_counter u_chain (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .clear_in(count_clear),
    .tick_in(count_tick),
    .limit_in(tap_limit),
    .terminal_out(terminal)
  );

  // ************************************************************
  // Watchdog arm state
  // ************************************************************

  // The first service instruction arms; a restart disarms and wins.
  assign running_nxt = restart ? 1'b0 :
                       wdog_instr_in ? 1'b1 : running_r;

  // ************************************************************
  // Mode register and write window
  // ************************************************************

  // Mode contents return to default on every restart.
  assign mode_nxt = restart ? WDWS_MODE_RESET :
                    mode_wr ? reg_wdata_in : mode_r;

  // The window counter reaches its last clock after 120 crystal clocks.
  assign win_done = (win_cnt_r == WDWS_WIN_LAST);

  // Window sequence: wait for the first instruction, open, then shut.
  always_comb begin
    win_state_nxt = win_state_r;
    win_cnt_nxt = win_cnt_r;
    if (restart) begin
      win_state_nxt = WDWS_WIN_WAIT;
      win_cnt_nxt = '0;
    end else begin
      case (win_state_r)
        WDWS_WIN_WAIT: begin
          if (first_instr_in) begin
            win_state_nxt = WDWS_WIN_OPEN;
            win_cnt_nxt = '0;
          end
        end
        WDWS_WIN_OPEN: begin
          if (win_done) begin
            win_state_nxt = WDWS_WIN_SHUT;
          end else begin
            win_cnt_nxt = win_cnt_r + WDWS_WIN_W'(1);
          end
        end
        WDWS_WIN_SHUT: begin
          win_state_nxt = WDWS_WIN_SHUT;
        end
        default: begin
          win_state_nxt = WDWS_WIN_WAIT;
          win_cnt_nxt = '0;
        end
      endcase
    end
  end

  // ************************************************************
  // Stop recovery control and start status
  // ************************************************************

  // Software sets only the level select; the status bit ignores writes.
  assign edge_sel_nxt = ctrl_wr ? reg_wdata_in[WDWS_EDGE_SEL_BIT] : edge_sel_r;

  // A wake in the same cycle as another reset still reads as warm.
  assign cold_warm_nxt = wake_now ? 1'b1 :
                         (timeout_fire || ext_rst_in) ? 1'b0 : cold_warm_r;

  // ************************************************************
  // Read path
  // ************************************************************

  // The mode register reads back a fixed value, never its contents.
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_in) begin
      if (sel_mode) begin
        rdata_nxt = WDWS_WO_READ_VALUE;
      end else if (sel_ctrl) begin
        rdata_nxt = WDWS_IDLE_READ_VALUE;
        rdata_nxt[WDWS_COLD_WARM_BIT] = cold_warm_r;
        rdata_nxt[WDWS_EDGE_SEL_BIT] = edge_sel_r;
      end else begin
        rdata_nxt = WDWS_IDLE_READ_VALUE;
      end
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************

  // Watchdog arm, mode register and level select.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      running_r <= 1'b0;
      mode_r <= WDWS_MODE_RESET;
      edge_sel_r <= WDWS_EDGE_SEL_RESET;
    end else begin
      running_r <= running_nxt;
      mode_r <= mode_nxt;
      edge_sel_r <= edge_sel_nxt;
    end
  end

  // Write window sequence.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      win_state_r <= WDWS_WIN_WAIT;
      win_cnt_r <= '0;
      win_open_r <= 1'b0;
    end else begin
      win_state_r <= win_state_nxt;
      win_cnt_r <= win_cnt_nxt;
      win_open_r <= (win_state_nxt == WDWS_WIN_OPEN);
    end
  end

  // Start status; power-on leaves it cold.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cold_warm_r <= 1'b0;
    end else begin
      cold_warm_r <= cold_warm_nxt;
    end
  end

  // Restart pulses towards the core.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_reset_r <= 1'b0;
      stop_wake_r <= 1'b0;
    end else begin
      cpu_reset_r <= timeout_fire;
      stop_wake_r <= wake_now;
    end
  end

  // Condition flags written on each service instruction.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_we_r <= 1'b0;
      flag_zsv_r <= WDWS_ZSV_AFTER_SERVICE;
    end else begin
      flag_we_r <= wdog_instr_in;
      flag_zsv_r <= WDWS_ZSV_AFTER_SERVICE;
    end
  end

  // Read data holds until the next read.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r <= WDWS_IDLE_READ_VALUE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  assign reg_rdata_out = rdata_r;
  assign cpu_reset_out = cpu_reset_r;
  assign stop_wake_out = stop_wake_r;
  assign wdog_running_out = running_r;
  assign write_window_out = win_open_r;
  assign flag_we_out = flag_we_r;
  assign flag_zsv_out = flag_zsv_r;

endmodule // wdws_watchdog

// ### inc/wdws_pkg.sv
// Shared constants and types for the watchdog and wake status block.
package wdws_pkg;

  // ************************************************************
  // Register access
  // ************************************************************

  // Expanded register bank that holds both registers.
  localparam logic [3:0] WDWS_BANK_F = 4'hF;
  // Location of the write-only watchdog mode register.
  localparam logic [7:0] WDWS_ADDR_WDOG_MODE = 8'h0F;
  // Location of the stop recovery control register.
  localparam logic [7:0] WDWS_ADDR_STOP_CTRL = 8'h0B;
  // Value returned when the write-only mode register is read.
  localparam logic [7:0] WDWS_WO_READ_VALUE = 8'h00;
  // Value returned for any location this block does not own.
  localparam logic [7:0] WDWS_IDLE_READ_VALUE = 8'h00;

  // ************************************************************
  // Field layout
  // ************************************************************

  // Tap select field of the watchdog mode register.
  localparam int WDWS_TAP_LSB = 0;
  localparam int WDWS_TAP_MSB = 1;
  // Keep counting while the core is halted.
  localparam int WDWS_HALT_RUN_BIT = 2;
  // Keep counting while the device is stopped.
  localparam int WDWS_STOP_RUN_BIT = 3;
  // Recovery level select in the stop recovery control register.
  localparam int WDWS_EDGE_SEL_BIT = 6;
  // Cold or warm start bit in the stop recovery control register.
  localparam int WDWS_COLD_WARM_BIT = 7;
  // Mode register contents after any qualifying restart.
  localparam logic [7:0] WDWS_MODE_RESET = 8'h00;
  // Recovery level select value after power-on.
  localparam logic WDWS_EDGE_SEL_RESET = 1'b0;

  // ************************************************************
  // Timing
  // ************************************************************

  // Width of the watchdog count chain.
  localparam int WDWS_CNT_W = 16;
  // Oscillator ticks to timeout for each tap select value.
  localparam logic [WDWS_CNT_W-1:0] WDWS_TAP_LIMIT [4] = '{
    16'h0100, 16'h0200, 16'h0400, 16'h1000
  };
  // Processor cycles that the mode register stays writable.
  localparam int WDWS_WIN_CPU_CYCLES = 60;
  // Crystal clocks per processor cycle; clock_in is the crystal clock.
  localparam int WDWS_CRYSTAL_CLOCK_PER_CPU = 2;
  // Length of the write window in clock_in cycles.
  localparam int WDWS_WIN_CLOCKS = WDWS_WIN_CPU_CYCLES * WDWS_CRYSTAL_CLOCK_PER_CPU;
  localparam int WDWS_WIN_W = 7;
  localparam logic [WDWS_WIN_W-1:0] WDWS_WIN_LAST = 7'(WDWS_WIN_CLOCKS - 1);

  // Zero, sign and overflow values left by the service instruction.
  localparam logic [2:0] WDWS_ZSV_AFTER_SERVICE = 3'h0;

  // ************************************************************
  // Write window states
  // ************************************************************

  typedef enum logic [1:0] {
    WDWS_WIN_WAIT = 2'b00,
    WDWS_WIN_OPEN = 2'b01,
    WDWS_WIN_SHUT = 2'b10
  } wdws_win_type;

endpackage

// ### logic/wdws_tap_counter.sv
// Retriggerable count chain that flags the selected terminal count.
`timescale 1ns/10ps
module wdws_tap_counter
  import wdws_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Control.
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic [WDWS_CNT_W-1:0] limit_in,
  // Result.
  output logic terminal_out
);

  logic [WDWS_CNT_W-1:0] count_r;
  logic [WDWS_CNT_W-1:0] count_nxt;
  logic terminal_r;
  logic terminal_nxt;
  wire logic hit;

  // The last tick before the limit is the terminal count.
  assign hit = tick_in && (count_r == limit_in - WDWS_CNT_W'(1));

  // Next count: clear wins, the chain wraps at terminal count.
  assign count_nxt = clear_in ? '0 :
                     hit ? '0 :
                     tick_in ? count_r + WDWS_CNT_W'(1) : count_r;
  assign terminal_nxt = hit && !clear_in;

  // Count and terminal pulse registers.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_r <= '0;
      terminal_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      terminal_r <= terminal_nxt;
    end
  end

  assign terminal_out = terminal_r;

endmodule // wdws_tap_counter

// ### tb/wdws_watchdog_sva.sv
// Concurrent checks on the ports of the watchdog and wake status block.
`timescale 1ns/10ps
module wdws_watchdog_sva
  import wdws_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Watched inputs.
  input wire logic ext_rst_in,
  input wire logic wdog_instr_in,
  input wire logic stop_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_bank_in,
  input wire logic [7:0] reg_addr_in,
  // Watched outputs.
  input wire logic [7:0] reg_rdata_out,
  input wire logic cpu_reset_out,
  input wire logic stop_wake_out,
  input wire logic wdog_running_out,
  input wire logic write_window_out,
  input wire logic flag_we_out,
  input wire logic [2:0] flag_zsv_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  // ************************************************************
  // Helper logic
  // ************************************************************

  // A read strobe aimed at the write-only mode register.
  wire rd_mode_w = reg_rd_in && reg_bank_in == WDWS_BANK_F && reg_addr_in == WDWS_ADDR_WDOG_MODE;
  // A service request that no external reset or stop wake can override.
  wire svc_w = wdog_instr_in && !ext_rst_in && !stop_in && !cpu_reset_out;
  logic [6:0] win_cnt_r;
  logic rd_mode_r;

  // Counts the cycles the write window has been open so far.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      win_cnt_r <= 7'h00;
      rd_mode_r <= 1'b0;
    end else begin
      win_cnt_r <= write_window_out ? win_cnt_r + 7'h01 : 7'h00;
      rd_mode_r <= rd_mode_w;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************

  service_flag_a: assert property (svc_w |=> flag_we_out &&
      flag_zsv_out == WDWS_ZSV_AFTER_SERVICE)
    else $error("service did not update the flags");
  // A timeout in the service cycle wins, and shows as a core reset next cycle.
  arm_on_service_a: assert property (svc_w |=> wdog_running_out || cpu_reset_out)
    else $error("service did not leave the watchdog running");
  idle_no_reset_a: assert property (!wdog_running_out |=> !cpu_reset_out)
    else $error("reset issued by an idle watchdog");
  reset_disarms_a: assert property (cpu_reset_out |->
      !wdog_running_out ##1 !write_window_out)
    else $error("watchdog still armed after its reset");
  reset_pulse_a: assert property (cpu_reset_out |=> !cpu_reset_out)
    else $error("core reset wider than one cycle");
  win_max_a: assert property (write_window_out |-> win_cnt_r < 7'h78)
    else $error("write window open too long");
  win_close_a: assert property ($fell(write_window_out) |->
      win_cnt_r == 7'h78 || $past(ext_rst_in) || cpu_reset_out || stop_wake_out)
    else $error("write window closed early");
  wake_clears_a: assert property (stop_wake_out |-> !wdog_running_out && !write_window_out)
    else $error("stop wake did not restart the block");
  wake_needs_stop_a: assert property (stop_wake_out |-> $past(stop_in))
    else $error("stop wake outside stop mode");
  mode_read_zero_a: assert property (rd_mode_r |-> reg_rdata_out == WDWS_WO_READ_VALUE)
    else $error("mode register contents readable");
  rdata_hold_a: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  // Main scenarios reached.
  cover property (cpu_reset_out);
  cover property (stop_wake_out);
  cover property ($fell(write_window_out) && win_cnt_r == 7'h78);
endmodule // wdws_watchdog_sva

bind wdws_watchdog wdws_watchdog_sva u_sva (.clock_in, .nrst_in, .ext_rst_in, .wdog_instr_in,
  .stop_in, .reg_rd_in, .reg_bank_in, .reg_addr_in, .reg_rdata_out, .cpu_reset_out,
  .stop_wake_out, .wdog_running_out, .write_window_out, .flag_we_out, .flag_zsv_out);

// ### tb/wdws_watchdog_bench.sv
// Self-checking bench for the watchdog and wake status block.
`timescale 1ns/10ps
module wdws_watchdog_bench
  import wdws_pkg::*;
;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ext_rst_in = 1'b0;
  logic first_instr_in = 1'b0;
  logic wdog_instr_in = 1'b0;
  logic halt_in = 1'b0;
  logic stop_in = 1'b0;
  logic recovery_src_in = 1'b1;
  logic rc_tick_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [3:0] reg_bank_in = 4'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic cpu_reset_out;
  logic stop_wake_out;
  logic wdog_running_out;
  logic write_window_out;
  logic flag_we_out;
  logic [2:0] flag_zsv_out;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [7:0] q;

  wdws_watchdog dut (.clock_in, .nrst_in, .ext_rst_in, .first_instr_in, .wdog_instr_in,
    .halt_in, .stop_in, .recovery_src_in, .rc_tick_in, .reg_wr_in, .reg_rd_in, .reg_bank_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .cpu_reset_out, .stop_wake_out,
    .wdog_running_out, .write_window_out, .flag_we_out, .flag_zsv_out);

  // The 40 MHz crystal clock.
  always #12.5 clock_in = ~clock_in;

  // ************************************************************
  // Tasks
  // ************************************************************

  // Compares one result and reports a difference at once.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Core event pulse: 0 first instruction, 1 service, above 1 external reset.
  task automatic pulse(input int which);
    @(posedge clock_in);
    first_instr_in <= (which == 0);
    wdog_instr_in <= (which == 1);
    ext_rst_in <= (which > 1);
    @(posedge clock_in);
    first_instr_in <= 1'b0;
    wdog_instr_in <= 1'b0;
    ext_rst_in <= 1'b0;
  endtask

  // One register access; read data is taken after the answering edge.
  task automatic acc(input logic wr, input logic [3:0] bank, input logic [7:0] addr,
                     input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_in <= wr;
    reg_rd_in <= !wr;
    reg_bank_in <= bank;
    reg_addr_in <= addr;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1 q = reg_rdata_out;
  endtask

  // Counts cycles until a core reset, giving up after lim cycles.
  task automatic wait_rst(input int lim);
    n = 0;
    while (n < lim && cpu_reset_out !== 1'b1) begin
      @(posedge clock_in);
      #1 n++;
    end
  endtask

  // Checks that the core reset arrives close to lim ticks.
  task automatic tmo(input int lim, input string what);
    wait_rst(lim + 8);
    chk(what, 16'h0001, 16'(n >= lim - 2 && n <= lim + 4));
  endtask

  // Cuts a hung run short.
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ************************************************************
  // Tests
  // ************************************************************

  initial begin
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    rc_tick_in <= 1'b1;
    acc(1'b0, WDWS_BANK_F, WDWS_ADDR_STOP_CTRL, 8'h00);
    chk("stop_ctrl", 16'h0000, 16'(q));
    acc(1'b0, 4'h0, WDWS_ADDR_WDOG_MODE, 8'h00);
    chk("unmapped", 16'(WDWS_IDLE_READ_VALUE), 16'(q));
    $display("test reset values done");
    // Window length, reserved bits and refused late writes.
    pulse(0);
    #1 chk("window_open", 16'h0001, 16'(write_window_out));
    acc(1'b1, WDWS_BANK_F, WDWS_ADDR_WDOG_MODE, 8'hF0);
    n = 2;
    while (write_window_out === 1'b1 && n < 200) begin
      @(posedge clock_in);
      #1 n++;
    end
    chk("window_len", 16'd120, 16'(n));
    acc(1'b1, WDWS_BANK_F, WDWS_ADDR_WDOG_MODE, 8'h03);
    acc(1'b0, WDWS_BANK_F, WDWS_ADDR_WDOG_MODE, 8'h00);
    chk("mode_read", 16'(WDWS_WO_READ_VALUE), 16'(q));
    wait_rst(300);
    chk("idle", 16'd300, 16'(n));
    chk("disarmed", 16'h0000, 16'(wdog_running_out));
    pulse(1);
    #1 chk("flags", 16'h0008, {12'h000, flag_we_out, flag_zsv_out});
    chk("armed", 16'h0001, 16'(wdog_running_out));
    tmo(256, "tap0");
    $display("test window and tap0 done");
    // Retrigger with the second tap.
    pulse(0);
    acc(1'b1, WDWS_BANK_F, WDWS_ADDR_WDOG_MODE, 8'h01);
    pulse(1);
    wait_rst(400);
    chk("before_refresh", 16'd400, 16'(n));
    pulse(1);
    tmo(512, "tap1_refresh");
    $display("test retrigger done");
    // Halt then stop: frozen with the run bit clear, counting with it set.
    for (int k = 0; k < 2; k++) begin
      pulse(0);
      pulse(1);
      @(posedge clock_in);
      halt_in <= (k == 0);
      stop_in <= (k == 1);
      wait_rst(300);
      chk("frozen", 16'd300, 16'(n));
      @(posedge clock_in);
      halt_in <= 1'b0;
      stop_in <= 1'b0;
      wait_rst(300);
      chk("resumed", 16'h0001, 16'(n < 300));
      pulse(0);
      acc(1'b1, WDWS_BANK_F, WDWS_ADDR_WDOG_MODE, (k == 0) ? 8'h04 : 8'h08);
      pulse(1);
      @(posedge clock_in);
      halt_in <= (k == 0);
      stop_in <= (k == 1);
      tmo(256, "run_bit");
      @(posedge clock_in);
      halt_in <= 1'b0;
      stop_in <= 1'b0;
    end
    $display("test halt and stop done");
    // Stop wake on a high level, cold or warm bit, external reset.
    pulse(0);
    pulse(1);
    acc(1'b1, WDWS_BANK_F, WDWS_ADDR_STOP_CTRL, 8'hC0);
    @(posedge clock_in);
    recovery_src_in <= 1'b0;
    stop_in <= 1'b1;
    wait_rst(300);
    chk("no_wake", 16'd300, 16'(n));
    @(posedge clock_in);
    recovery_src_in <= 1'b1;
    @(posedge clock_in);
    #1 chk("wake", 16'h0001, 16'(stop_wake_out));
    @(posedge clock_in);
    stop_in <= 1'b0;
    acc(1'b0, WDWS_BANK_F, WDWS_ADDR_STOP_CTRL, 8'h00);
    chk("warm", 16'h00C0, 16'(q));
    pulse(2);
    acc(1'b0, WDWS_BANK_F, WDWS_ADDR_STOP_CTRL, 8'h00);
    chk("cold", 16'h0040, 16'(q));
    // Low level select: a low source wakes the device.
    acc(1'b1, WDWS_BANK_F, WDWS_ADDR_STOP_CTRL, 8'h00);
    @(posedge clock_in);
    recovery_src_in <= 1'b0;
    stop_in <= 1'b1;
    @(posedge clock_in);
    #1 chk("wake_low", 16'h0001, 16'(stop_wake_out));
    @(posedge clock_in);
    stop_in <= 1'b0;
    acc(1'b0, WDWS_BANK_F, WDWS_ADDR_STOP_CTRL, 8'h00);
    chk("warm_low", 16'h0080, 16'(q));
    $display("test stop wake done");
    end_of_test();
  end
endmodule // wdws_watchdog_bench
